// ### verilog/uart_irq_map.vh
`ifndef UART_IRQ_MAP_VH
`define UART_IRQ_MAP_VH

// Register addresses
`define ADR_STATUS   16'h4100
`define ADR_TXD      16'h4101
`define ADR_RXD      16'h4102
`define ADR_FORMAT   16'h4103
`define ADR_CONTROL  16'h4104
`define ADR_IRSETUP  16'h4105
`define ADR_DIVISOR  16'h4106
`define ADR_FINE     16'h4107
`define ADR_CLKSEL   16'h506c

// Status bits
`define ST_DONE  7
`define ST_FER   6
`define ST_PER   5
`define ST_OER   4
`define ST_RX_SECOND_BYTE_FLAG  3
`define ST_BUSY  2
`define ST_RX_DATA_READY_FLAG  1
`define ST_TX_BUFFER_EMPTY_FLAG  0
`define ST_W1C_LO 4

// Control bits
`define CTL_XFER   0
`define CTL_DEPTH  1
`define CTL_TX_EMPTY_IRQ_ENABLE   2
`define CTL_TX_END_IRQ_ENABLE  3
`define CTL_RX_FULL_IRQ_ENABLE   4
`define CTL_RX_ERROR_IRQ_ENABLE  5

// Frame format bits
`define FMT_STOP2  1
`define FMT_ODD    2
`define FMT_PAR    3
`define FMT_LEN8   4

// Infrared setup and clock select bits
`define IR_ENABLE  0
`define CK_ENABLE  0

// Writable bit masks
`define MASK_FORMAT  8'h1e
`define MASK_CONTROL 8'h3f
`define MASK_IRSETUP 8'h01
`define MASK_FINE    8'h0f
`define MASK_CLKSEL  8'h3f

// Reset values
`define RST_REG    8'h00
`define RST_TX_BUFFER_EMPTY_FLAG   1'b1

// Oversampling timing
`define OS_LAST    4'hf
`define OS_MID     4'h7
`define IR_TX_LOW  4'h3
`define IR_STRETCH 5'h10

`endif

// ### verilog/uart_irq_status_irda.v
// Notes on behaviour
// - One shared request line for all causes
// - Enables reset to 0 and gate causes
// - Buffer-to-shifter move sets empty flag, requests
// - Busy falling at frame end sets done flag, requests
// - Receive request at one or two bytes
// - Receive errors set flags and request
// - Infrared transmit low bit is 3-tick pulse
// - Infrared receive pulse stretched to 16 ticks
// - Pulse detector on the system clock
// - Infrared enable switches shaping into path
// - Infrared mode keeps all other behaviour
// - All registers eight bits wide
// - Done and error flags at D7..D4
// - Second byte, busy, ready flags read-only
// - Buffer empty flag D0 resets to 1
// - Error flags cleared by writing 1
// - Second byte flag clears on first read
`include "uart_irq_map.vh"

module uart_irq_status_irda (
	// Clock and reset
	input  wire       CLK,
	input  wire       RESET_N,
	// Register port
	input  wire [15:0] ADDR,
	input  wire [7:0]  WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [7:0]  RDATA,
	// Serial line
	input  wire        SIN,
	output reg         SOUT,
	// Interrupt request
	output wire        IRQ
);

	localparam TS_IDLE  = 2'b01;
	localparam TS_SHIFT = 2'b10;
	localparam RS_IDLE  = 3'b001;
	localparam RS_START = 3'b010;
	localparam RS_DATA  = 3'b100;

	// Builds a frame LSB first: start, data, parity, stops
	function [11:0] tx_frame;
		input [7:0] d;
		input [7:0] m;
		reg   [11:0] f;
		reg          p;
		begin
			f = 12'hfff;
			p = ^(d & (m[`FMT_LEN8] ? 8'hff : 8'h7f)) ^ m[`FMT_ODD];
			f[0] = 1'b0;
			if (m[`FMT_LEN8]) begin
				f[8:1] = d;
				if (m[`FMT_PAR])
					f[9] = p;
			end else begin
				f[7:1] = d[6:0];
				if (m[`FMT_PAR])
					f[8] = p;
			end
			tx_frame = f;
		end
	endfunction

	reg        rst_meta_q;
	reg        rst_sync_q;
	wire       rst_n;

	reg  [7:0] fmt_q;
	reg  [7:0] ctl_q;
	reg  [7:0] irs_q;
	reg  [7:0] div_q;
	reg  [7:0] fine_q;
	reg  [7:0] cks_q;
	reg  [7:0] txd_q;

	reg  [7:0] os_cnt_q;
	reg        os_tick_q;

	reg  [1:0]  ts_q;
	reg  [11:0] tx_sh_q;
	reg  [3:0]  tx_bits_q;
	reg  [3:0]  tx_ph_q;
	reg         tx_buffer_empty_flag_q;
	reg         busy_q;
	reg         tx_end_q;

	reg         sin_prev_q;
	reg  [4:0]  ir_cnt_q;
	wire        rx_line;

	reg  [2:0]  rs_q;
	reg  [3:0]  rx_ph_q;
	reg  [3:0]  rx_idx_q;
	reg  [3:0]  rx_last_q;
	reg  [9:0]  rx_sh_q;
	reg         rx_push_q;
	reg  [7:0]  rx_byte_q;
	reg         rx_fe_q;
	reg         rx_pe_q;

	reg  [7:0]  fifo_mem [0:1];
	reg         wr_ptr_q;
	reg         rd_ptr_q;
	reg  [1:0]  fifo_cnt_q;

	reg  [7:4]  st_w1c_q;
	wire [7:4]  st_set;
	wire [7:4]  st_clr;

	wire xfer     = ctl_q[`CTL_XFER];
	wire ir_mode  = irs_q[`IR_ENABLE];
	wire wr_txd   = WR && (ADDR == `ADR_TXD);
	wire wr_stat  = WR && (ADDR == `ADR_STATUS);
	wire pop      = RD && (ADDR == `ADR_RXD) && (fifo_cnt_q != 2'd0);
	wire tx_load  = (ts_q == TS_IDLE) && !tx_buffer_empty_flag_q && xfer;
	wire push_ok  = rx_push_q && ((fifo_cnt_q != 2'd2) || pop);
	wire overrun  = rx_push_q && !push_ok;
	wire rx_data_ready_flag     = (fifo_cnt_q != 2'd0);
	wire rx_second_byte_flag     = (fifo_cnt_q == 2'd2);
	wire [7:0] status = {st_w1c_q, rx_second_byte_flag, busy_q, rx_data_ready_flag, tx_buffer_empty_flag_q};

	// Reset release through two flops
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	// Setup registers; reserved bits are masked off
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			fmt_q  <= `RST_REG;
			ctl_q  <= `RST_REG;
			irs_q  <= `RST_REG;
			div_q  <= `RST_REG;
			fine_q <= `RST_REG;
			cks_q  <= `RST_REG;
			txd_q  <= `RST_REG;
		end else if (WR) begin
			case (ADDR)
			`ADR_FORMAT:  fmt_q  <= WDATA & `MASK_FORMAT;
			`ADR_CONTROL: ctl_q  <= WDATA & `MASK_CONTROL;
			`ADR_IRSETUP: irs_q  <= WDATA & `MASK_IRSETUP;
			`ADR_DIVISOR: div_q  <= WDATA;
			`ADR_FINE:    fine_q <= WDATA & `MASK_FINE;
			`ADR_CLKSEL:  cks_q  <= WDATA & `MASK_CLKSEL;
			`ADR_TXD:     txd_q  <= WDATA;
			default: ;
			endcase
		end
	end

	// Oversampling enable: one tick every divisor+1 cycles
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			os_cnt_q  <= 8'h00;
			os_tick_q <= 1'b0;
		end else if (!cks_q[`CK_ENABLE]) begin
			os_cnt_q  <= 8'h00;
			os_tick_q <= 1'b0;
		end else if (os_cnt_q == div_q) begin
			os_cnt_q  <= 8'h00;
			os_tick_q <= 1'b1;
		end else begin
			os_cnt_q  <= os_cnt_q + 8'h01;
			os_tick_q <= 1'b0;
		end
	end

	// Transmit buffer and shifter
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ts_q      <= TS_IDLE;
			tx_sh_q   <= 12'hfff;
			tx_bits_q <= 4'h0;
			tx_ph_q   <= 4'h0;
			tx_buffer_empty_flag_q    <= `RST_TX_BUFFER_EMPTY_FLAG;
			busy_q    <= 1'b0;
			tx_end_q  <= 1'b0;
		end else begin
			tx_end_q <= 1'b0;
			// A new write wins over the load that empties the buffer
			if (wr_txd)
				tx_buffer_empty_flag_q <= 1'b0;
			else if (tx_load || !xfer)
				tx_buffer_empty_flag_q <= 1'b1;
			case (ts_q)
			TS_IDLE: begin
				if (tx_load) begin
					ts_q      <= TS_SHIFT;
					tx_sh_q   <= tx_frame(txd_q, fmt_q);
					tx_bits_q <= 4'd9 + {3'd0, fmt_q[`FMT_LEN8]} + {3'd0, fmt_q[`FMT_PAR]}
						+ {3'd0, fmt_q[`FMT_STOP2]};
					tx_ph_q   <= 4'h0;
					busy_q    <= 1'b1;
				end
			end
			TS_SHIFT: begin
				if (!xfer) begin
					// Abort drops the frame without signalling completion
					ts_q    <= TS_IDLE;
					busy_q  <= 1'b0;
					tx_sh_q <= 12'hfff;
				end else if (os_tick_q) begin
					tx_ph_q <= tx_ph_q + 4'h1;
					if (tx_ph_q == `OS_LAST) begin
						tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
						tx_bits_q <= tx_bits_q - 4'h1;
						if (tx_bits_q == 4'h1) begin
							ts_q     <= TS_IDLE;
							busy_q   <= 1'b0;
							tx_end_q <= 1'b1;
						end
					end
				end
			end
			default: ts_q <= TS_IDLE;
			endcase
		end
	end

	// Line output, with optional return-to-zero shaping
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			SOUT <= 1'b1;
		else if (ts_q != TS_SHIFT)
			SOUT <= 1'b1;
		else if (ir_mode)
			SOUT <= tx_sh_q[0] || (tx_ph_q >= `IR_TX_LOW);
		else
			SOUT <= tx_sh_q[0];
	end

	// Pulse detector sampled on every system clock, far finer than the shortest pulse
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			sin_prev_q <= 1'b1;
			ir_cnt_q   <= 5'h00;
		end else begin
			sin_prev_q <= SIN;
			if (!ir_mode)
				ir_cnt_q <= 5'h00;
			else if (!SIN && sin_prev_q)
				ir_cnt_q <= `IR_STRETCH;
			else if (os_tick_q && (ir_cnt_q != 5'h00))
				ir_cnt_q <= ir_cnt_q - 5'h01;
		end
	end
	assign rx_line = ir_mode ? (ir_cnt_q == 5'h00) : SIN;

	// Receive shifter
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			rs_q      <= RS_IDLE;
			rx_ph_q   <= 4'h0;
			rx_idx_q  <= 4'h0;
			rx_last_q <= 4'h0;
			rx_sh_q   <= 10'h000;
			rx_push_q <= 1'b0;
			rx_byte_q <= 8'h00;
			rx_fe_q   <= 1'b0;
			rx_pe_q   <= 1'b0;
		end else begin
			rx_push_q <= 1'b0;
			if (!xfer)
				rs_q <= RS_IDLE;
			else if (os_tick_q) begin
				case (rs_q)
				RS_IDLE: begin
					rx_ph_q <= 4'h0;
					if (!rx_line)
						rs_q <= RS_START;
				end
				RS_START: begin
					rx_ph_q <= rx_ph_q + 4'h1;
					if (rx_ph_q == `OS_MID) begin
						// Start bit is confirmed at mid bit
						rx_ph_q   <= 4'h0;
						rx_idx_q  <= 4'h0;
						rx_sh_q   <= 10'h000;
						rx_last_q <= 4'd7 + {3'd0, fmt_q[`FMT_LEN8]}
							+ {3'd0, fmt_q[`FMT_PAR]};
						rs_q      <= rx_line ? RS_IDLE : RS_DATA;
					end
				end
				RS_DATA: begin
					rx_ph_q <= rx_ph_q + 4'h1;
					if (rx_ph_q == `OS_LAST) begin
						rx_sh_q[rx_idx_q] <= rx_line;
						rx_idx_q <= rx_idx_q + 4'h1;
						if (rx_idx_q == rx_last_q) begin
							// Only the first stop bit is checked
							rs_q      <= RS_IDLE;
							rx_push_q <= 1'b1;
							rx_fe_q   <= !rx_line;
							if (fmt_q[`FMT_LEN8]) begin
								rx_byte_q <= rx_sh_q[7:0];
								rx_pe_q   <= fmt_q[`FMT_PAR]
									&& (^rx_sh_q[8:0] ^ fmt_q[`FMT_ODD]);
							end else begin
								rx_byte_q <= {1'b0, rx_sh_q[6:0]};
								rx_pe_q   <= fmt_q[`FMT_PAR]
									&& (^rx_sh_q[7:0] ^ fmt_q[`FMT_ODD]);
							end
						end
					end
				end
				default: rs_q <= RS_IDLE;
				endcase
			end
		end
	end

	// Two-entry receive buffer; a full buffer keeps its data on overrun
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q    <= 1'b0;
			rd_ptr_q    <= 1'b0;
			fifo_cnt_q  <= 2'd0;
			fifo_mem[0] <= 8'h00;
			fifo_mem[1] <= 8'h00;
		end else begin
			if (push_ok) begin
				fifo_mem[wr_ptr_q] <= rx_byte_q;
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			if (push_ok && !pop)
				fifo_cnt_q <= fifo_cnt_q + 2'd1;
			else if (pop && !push_ok)
				fifo_cnt_q <= fifo_cnt_q - 2'd1;
		end
	end

	// Sticky done and error flags, write 1 to clear, set wins
	assign st_set = {tx_end_q, push_ok && rx_fe_q, push_ok && rx_pe_q, overrun};
	assign st_clr = wr_stat ? WDATA[7:4] : 4'h0;
	genvar gi;
	generate
		for (gi = `ST_W1C_LO; gi <= `ST_DONE; gi = gi + 1) begin : g_w1c
			always @(posedge CLK or negedge rst_n) begin
				if (!rst_n)
					st_w1c_q[gi] <= 1'b0;
				else if (st_set[gi])
					st_w1c_q[gi] <= 1'b1;
				else if (st_clr[gi])
					st_w1c_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// Read data stands in the cycle after the strobe only
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			RDATA <= 8'h00;
		else if (!RD)
			RDATA <= 8'h00;
		else begin
			case (ADDR)
			`ADR_STATUS:  RDATA <= status;
			`ADR_TXD:     RDATA <= txd_q;
			`ADR_RXD:     RDATA <= rx_data_ready_flag ? fifo_mem[rd_ptr_q] : 8'h00;
			`ADR_FORMAT:  RDATA <= fmt_q;
			`ADR_CONTROL: RDATA <= ctl_q;
			`ADR_IRSETUP: RDATA <= irs_q;
			`ADR_DIVISOR: RDATA <= div_q;
			`ADR_FINE:    RDATA <= fine_q;
			`ADR_CLKSEL:  RDATA <= cks_q;
			default:      RDATA <= 8'h00;
			endcase
		end
	end

	// Level request while any enabled cause flag is set; busy never requests
	assign IRQ = (ctl_q[`CTL_TX_EMPTY_IRQ_ENABLE] && tx_buffer_empty_flag_q)
		|| (ctl_q[`CTL_TX_END_IRQ_ENABLE] && st_w1c_q[`ST_DONE])
		|| (ctl_q[`CTL_RX_FULL_IRQ_ENABLE] && (ctl_q[`CTL_DEPTH] ? rx_second_byte_flag : rx_data_ready_flag))
		|| (ctl_q[`CTL_RX_ERROR_IRQ_ENABLE] && (|st_w1c_q[`ST_FER:`ST_OER]));

endmodule // uart_irq_status_irda

// ### tb/serial_peer.sv
module serial_peer (
	// Clock
	input  logic CLK,
	// Line toward the block
	output logic SIN
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ir = 1'b0;
	initial SIN = 1'b1;
	// Sixteen clocks a bit, so the bench must run divisor 0
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			for (int j = 0; j < 16; j++) begin
				@(posedge CLK);
				SIN <= (i == 10) | f[i % 10] | (ir & (j > 2));
			end
		end
	endtask
endmodule // serial_peer

// ### tb/uart_irq_sva.sv
`include "uart_irq_map.vh"
module uart_irq_sva (
	input logic        CLK,
	input logic        RESET_N,
	// Register port
	input logic [15:0] ADDR,
	input logic [7:0]  WDATA,
	input logic        WR,
	input logic        RD,
	input logic [7:0]  RDATA,
	// Line and request
	input logic        SIN,
	input logic        SOUT,
	input logic        IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctl_q;
	logic [7:0] div_q;
	logic       ir_q;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	// Shadow of the control, divisor and infrared setup written so far
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctl_q <= 8'h00;
			div_q <= 8'h00;
			ir_q  <= 1'b0;
		end else if (WR) begin
			if (ADDR == `ADR_CONTROL) ctl_q <= WDATA & `MASK_CONTROL;
			if (ADDR == `ADR_DIVISOR) div_q <= WDATA;
			if (ADDR == `ADR_IRSETUP) ir_q <= WDATA[0];
		end
	end
	function automatic logic want(input logic [7:0] c, input logic [7:0] s);
		return (c[2] & s[0]) | (c[3] & s[7]) | (c[4] & (c[1] ? s[3] : s[1])) | (c[5] & |s[6:4]);
	endfunction
	rdata_idle_a: assert property (
		!$past(RD) |-> RDATA == 8'h00) else $error("read data outside read");
	unmapped_read_a: assert property (
		RD && ADDR == 16'h4108 |=> RDATA == 8'h00) else $error("unmapped read not zero");
	irq_masked_a: assert property (
		ctl_q[5:2] == 4'h0 |-> !IRQ) else $error("request while all masked");
	irq_cause_a: assert property (
		RD && ADDR == `ADR_STATUS |=> $past(IRQ) == want($past(ctl_q), RDATA)) else $error("request mismatch");
	ctl_back_a: assert property (
		RD && ADDR == `ADR_CONTROL |=> RDATA == $past(ctl_q)) else $error("control readback");
	div_back_a: assert property (
		RD && ADDR == `ADR_DIVISOR |=> RDATA == $past(div_q)) else $error("divisor readback");
	ir_back_a: assert property (
		RD && ADDR == `ADR_IRSETUP |=> RDATA == {7'h00, $past(ir_q)}) else $error("infrared readback");
	// Only meaningful at divisor 0, where a tick is one clock
	ir_pulse_a: assert property (
		$fell(SOUT) && ir_q && div_q == 8'h00 |-> !SOUT [*3] ##1 SOUT) else $error("infrared pulse width");
endmodule // uart_irq_sva
bind uart_irq_status_irda uart_irq_sva i_sva (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .SIN(SIN), .SOUT(SOUT), .IRQ(IRQ));

// ### tb/testbench.sv
`include "uart_irq_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK = 1'b0;
	logic        RESET_N = 1'b0;
	logic [15:0] ADDR = 16'h0000;
	logic [7:0]  WDATA = 8'h00;
	logic        WR = 1'b0;
	logic        RD = 1'b0;
	logic [7:0]  RDATA;
	logic        SIN;
	logic        SOUT;
	logic        IRQ;
	logic [7:0]  v;
	int          failures = 0;
	int          samples_checked = 0;

	uart_irq_status_irda i_dut (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .SIN(SIN), .SOUT(SOUT), .IRQ(IRQ));
	serial_peer i_peer (.CLK(CLK), .SIN(SIN));

	initial begin
		forever #5 CLK = ~CLK;
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Settle past the edge before sampling outputs
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask

	task automatic t_reset;
		rd(`ADR_STATUS);
		chk("status", 8'h01, v);
		rd(`ADR_CONTROL);
		chk("control", 8'h00, v);
		rd(16'h4108);
		chk("unmapped", 8'h00, v);
		wr(`ADR_FORMAT, `MASK_FORMAT);
		rd(`ADR_FORMAT);
		chk("format", `MASK_FORMAT, v);
		wr(`ADR_FORMAT, 8'h10);
		wr(`ADR_DIVISOR, 8'h00);
		wr(`ADR_CLKSEL, 8'h01);
		rd(`ADR_DIVISOR);
		rd(`ADR_CLKSEL);
		chk("clock select", 8'h01, v);
		$display("reset test done");
	endtask

	task automatic t_tx;
		logic [9:0] f;
		int n;
		f = {1'b1, 8'h4b, 1'b0};
		wr(`ADR_CONTROL, 8'h09);
		wr(`ADR_TXD, 8'h4b);
		n = 0;
		while (SOUT !== 1'b0 && n < 8) begin
			tick(1);
			n++;
		end
		tick(8);
		for (int i = 0; i < 10; i++) begin
			chk("sout bit", {7'h00, f[i]}, {7'h00, SOUT});
			tick(16);
		end
		chk("tx end irq", 8'h01, {7'h00, IRQ});
		rd(`ADR_STATUS);
		chk("tx done", 8'h81, v);
		wr(`ADR_STATUS, 8'h80);
		rd(`ADR_STATUS);
		chk("done clear", 8'h01, v);
		chk("irq off", 8'h00, {7'h00, IRQ});
		wr(`ADR_CONTROL, 8'h05);
		tick(0);
		chk("tx empty irq", 8'h01, {7'h00, IRQ});
		wr(`ADR_CONTROL, 8'h00);
		$display("transmit test done");
	endtask

	task automatic t_rx;
		wr(`ADR_CONTROL, 8'h02);
		wr(`ADR_CONTROL, 8'h13);
		i_peer.send(8'ha5, 1'b1);
		chk("depth two waits", 8'h00, {7'h00, IRQ});
		i_peer.send(8'h3c, 1'b1);
		chk("rx irq two", 8'h01, {7'h00, IRQ});
		rd(`ADR_STATUS);
		chk("two bytes", 8'h0b, v);
		rd(`ADR_RXD);
		chk("first byte", 8'ha5, v);
		rd(`ADR_STATUS);
		chk("second clear", 8'h03, v);
		rd(`ADR_RXD);
		chk("second byte", 8'h3c, v);
		$display("receive test done");
	endtask

	task automatic t_err;
		wr(`ADR_CONTROL, 8'h22);
		wr(`ADR_CONTROL, 8'h23);
		i_peer.send(8'h00, 1'b0);
		chk("error irq", 8'h01, {7'h00, IRQ});
		rd(`ADR_STATUS);
		chk("framing flag", 8'h43, v);
		wr(`ADR_STATUS, 8'h40);
		rd(`ADR_STATUS);
		chk("framing clear", 8'h03, v);
		i_peer.send(8'h11, 1'b1);
		i_peer.send(8'h22, 1'b1);
		rd(`ADR_STATUS);
		chk("overrun flag", 8'h1b, v);
		rd(`ADR_RXD);
		chk("oldest kept", 8'h00, v);
		rd(`ADR_RXD);
		chk("overrun drop", 8'h11, v);
		wr(`ADR_STATUS, 8'h10);
		// Parity sits where bit 7 would be in seven-bit frames
		wr(`ADR_CONTROL, 8'h22);
		wr(`ADR_FORMAT, 8'h08);
		wr(`ADR_CONTROL, 8'h23);
		i_peer.send(8'h01, 1'b1);
		chk("parity irq", 8'h01, {7'h00, IRQ});
		rd(`ADR_STATUS);
		chk("parity flag", 8'h23, v);
		rd(`ADR_RXD);
		chk("seven bit byte", 8'h01, v);
		wr(`ADR_CONTROL, 8'h22);
		wr(`ADR_FORMAT, 8'h10);
		wr(`ADR_STATUS, 8'h20);
		$display("error test done");
	endtask

	task automatic t_ir;
		wr(`ADR_CONTROL, 8'h02);
		wr(`ADR_CONTROL, 8'h00);
		wr(`ADR_IRSETUP, 8'h01);
		rd(`ADR_IRSETUP);
		wr(`ADR_CONTROL, 8'h11);
		i_peer.ir = 1'b1;
		i_peer.send(8'h5a, 1'b1);
		chk("ir rx irq", 8'h01, {7'h00, IRQ});
		rd(`ADR_RXD);
		chk("ir byte", 8'h5a, v);
		wr(`ADR_TXD, 8'h0f);
		tick(20);
		rd(`ADR_STATUS);
		chk("ir tx busy", 8'h05, v);
		tick(180);
		rd(`ADR_STATUS);
		chk("ir tx done", 8'h81, v);
		$display("infrared test done");
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge CLK);
		RESET_N <= 1'b1;
		tick(3);
		t_reset();
		t_tx();
		t_rx();
		t_err();
		t_ir();
		end_of_test();
	end
	// Whole run needs about 1700 clocks
	initial begin
		#100us;
		failures++;
		end_of_test();
	end
endmodule // testbench
